// *** verilog/aisp_defs.svh ***
// aisp register map constants and field positions for the summary/port A bank
// assumes inclusion by the bank and its decode module only
`ifndef AISP_DEFS_SVH
`define AISP_DEFS_SVH
`define AISP_ADDR_IRQ_SUM 8'h02
`define AISP_ADDR_PA_CTRL1 8'h03
`define AISP_ADDR_RX_STAT0 8'h14
`define AISP_ADDR_RX_STAT1 8'h15
`define AISP_ADDR_TX_STAT 8'h0a
`define AISP_SUM_TX_BIT 2
`define AISP_SUM_RX_BIT 1
`define AISP_PA_SILENCE_BIT 6
`define AISP_PA_SRC_HI 5
`define AISP_PA_SRC_LO 4
`define AISP_PA_ROLE_BIT 3
`define AISP_PA_FMT_HI 2
`define AISP_PA_FMT_LO 0
`define AISP_PA_CTRL1_RST 8'h00
`define AISP_FMT_LJ24 3'h0
`define AISP_FMT_I2S24 3'h1
`define AISP_FMT_RJ16 3'h4
`define AISP_FMT_RJ18 3'h5
`define AISP_FMT_RJ20 3'h6
`define AISP_FMT_RJ24 3'h7
`define AISP_FMT_UNUSED_A 3'h2
`define AISP_FMT_UNUSED_B 3'h3
`define AISP_SRC_LOOP 2'h0
`define AISP_SRC_PORT_B 2'h1
`define AISP_WLEN_16 5'h10
`define AISP_WLEN_18 5'h12
`define AISP_WLEN_20 5'h14
`define AISP_WLEN_24 5'h18
`endif

// *** verilog/aisp_pkg.sv ***
// aisp types shared by the register bank and its format decoder
// assumes aisp_defs.svh for numeric values
package aisp_pkg;
    typedef enum logic [1:0] {
        AISP_JUST_LEFT,
        AISP_JUST_I2S,
        AISP_JUST_RIGHT,
        AISP_JUST_NONE
    } aisp_just_t;

    typedef struct packed {
        logic silence;
        logic [1:0] src_sel;
        logic master;
        logic [2:0] fmt;
    } aisp_pa_ctrl_t;

    typedef struct packed {
        aisp_just_t just;
        logic [4:0] word_len;
        logic valid;
    } aisp_fmt_t;
endpackage : aisp_pkg

// *** verilog/aisp_fmt_dec.sv ***
// aisp format decoder: turns the three-bit word format into framing info
// assumes one shared decode serves both input and output paths of port A
`timescale 1ns/1ns
`include "aisp_defs.svh"
module aisp_fmt_dec (
    input wire logic [2:0] fmt,
    output aisp_pkg::aisp_fmt_t dec
);
    always_comb begin
        dec = '{just: aisp_pkg::AISP_JUST_NONE, word_len: 5'h00, valid: 1'b0};
        case (fmt)
            `AISP_FMT_LJ24: begin
                dec = '{aisp_pkg::AISP_JUST_LEFT, `AISP_WLEN_24, 1'b1};
            end
            `AISP_FMT_I2S24: begin
                dec = '{aisp_pkg::AISP_JUST_I2S, `AISP_WLEN_24, 1'b1};
            end
            `AISP_FMT_RJ16: begin
                dec = '{aisp_pkg::AISP_JUST_RIGHT, `AISP_WLEN_16, 1'b1};
            end
            `AISP_FMT_RJ18: begin
                dec = '{aisp_pkg::AISP_JUST_RIGHT, `AISP_WLEN_18, 1'b1};
            end
            `AISP_FMT_RJ20: begin
                dec = '{aisp_pkg::AISP_JUST_RIGHT, `AISP_WLEN_20, 1'b1};
            end
            `AISP_FMT_RJ24: begin
                dec = '{aisp_pkg::AISP_JUST_RIGHT, `AISP_WLEN_24, 1'b1};
            end
            default: begin
                // unused codes keep the port framing-less, valid low
                dec = '{aisp_pkg::AISP_JUST_NONE, 5'h00, 1'b0};
            end
        endcase
    end
endmodule : aisp_fmt_dec

// *** verilog/aisp_bank.sv ***
// aisp register bank: global interrupt summary and port A control one
// assumes a host interface front end presents byte reads/writes with a
// one-cycle write strobe; read data is registered one cycle after request
// Behaviour
// - register 02 read-only; bit 2 transmitter, bit 1 receiver, others zero.
// - receiver summary flag is high while any receiver source is active.
// - transmitter flag high while active; host then reads 0x0a.
// - register 03: bit7 zero, silence, source select, clock role, format.
// - one format field drives both input and output paths of port A.
// - format 000 LJ24 default, 001 I2S24, 010/011 unused, 100 RJ16.
// - role zero takes frame and bit clocks in; one drives them out.
// - source 00 loops port A input back, 01 selects port B input.
`timescale 1ns/1ns
`include "aisp_defs.svh"
module aisp_bank #(
    parameter int RX_SRCS = 16,
    parameter int TX_SRCS = 8
) (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic HOST_WR,
    input wire logic HOST_RD,
    input wire logic [7:0] HOST_ADDR,
    input wire logic [7:0] HOST_WDATA,
    output logic [7:0] HOST_RDATA,
    output logic HOST_RVALID,
    input wire logic [RX_SRCS-1:0] RX_PENDING,
    input wire logic [RX_SRCS-1:0] RX_ENABLE,
    input wire logic [TX_SRCS-1:0] TX_PENDING,
    input wire logic [TX_SRCS-1:0] TX_ENABLE,
    output aisp_pkg::aisp_pa_ctrl_t PA_CTRL,
    output aisp_pkg::aisp_fmt_t PA_IN_FMT,
    output aisp_pkg::aisp_fmt_t PA_OUT_FMT,
    input wire logic PA_SDATA_IN,
    input wire logic PB_SDATA_IN,
    output logic PA_SDATA_OUT,
    input wire logic PA_LEFT_RIGHT_FRAME_CLOCK_I,
    input wire logic PA_BCK_I,
    input wire logic PA_LEFT_RIGHT_FRAME_CLOCK_GEN,
    input wire logic PA_BCK_GEN,
    output logic PA_LEFT_RIGHT_FRAME_CLOCK_O,
    output logic PA_LEFT_RIGHT_FRAME_CLOCK_OE,
    output logic PA_BCK_O,
    output logic PA_BCK_OE,
    output logic PA_LEFT_RIGHT_FRAME_CLOCK_USE,
    output logic PA_BCK_USE
);
    aisp_pkg::aisp_pa_ctrl_t ctrl_r, ctrl_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    logic rx_sum_r, rx_sum_nxt;
    logic tx_sum_r, tx_sum_nxt;
    logic sdout_r, sdout_nxt;
    logic [7:0] sum_word;
    logic [7:0] ctrl_word;
    aisp_pkg::aisp_fmt_t fmt_dec;
    // reserved bit 7 is not stored, so only the low seven bits reach ctrl_r
    localparam logic [7:0] CTRL_RST_WORD = `AISP_PA_CTRL1_RST;

    always_comb begin
        // level flags: no latch, so they drop once sources clear
        rx_sum_nxt = |(RX_PENDING & RX_ENABLE);
        tx_sum_nxt = |(TX_PENDING & TX_ENABLE);
    end

    always_comb begin
        sum_word = 8'h00;
        sum_word[`AISP_SUM_TX_BIT] = tx_sum_r;
        sum_word[`AISP_SUM_RX_BIT] = rx_sum_r;
        ctrl_word = 8'h00;
        ctrl_word[`AISP_PA_SILENCE_BIT] = ctrl_r.silence;
        ctrl_word[`AISP_PA_SRC_HI:`AISP_PA_SRC_LO] = ctrl_r.src_sel;
        ctrl_word[`AISP_PA_ROLE_BIT] = ctrl_r.master;
        ctrl_word[`AISP_PA_FMT_HI:`AISP_PA_FMT_LO] = ctrl_r.fmt;
    end

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (HOST_WR && HOST_ADDR == `AISP_ADDR_PA_CTRL1) begin
            ctrl_nxt.silence = HOST_WDATA[`AISP_PA_SILENCE_BIT];
            ctrl_nxt.src_sel = HOST_WDATA[`AISP_PA_SRC_HI:`AISP_PA_SRC_LO];
            ctrl_nxt.master = HOST_WDATA[`AISP_PA_ROLE_BIT];
            ctrl_nxt.fmt = HOST_WDATA[`AISP_PA_FMT_HI:`AISP_PA_FMT_LO];
        end
        // writes to the summary address are dropped: it is read-only
        rvalid_nxt = HOST_RD;
        rdata_nxt = 8'h00;
        if (HOST_RD) begin
            if (HOST_ADDR == `AISP_ADDR_IRQ_SUM) begin
                rdata_nxt = sum_word;
            end else if (HOST_ADDR == `AISP_ADDR_PA_CTRL1) begin
                rdata_nxt = ctrl_word;
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    always_comb begin
        // silence forces the serial output low regardless of source
        sdout_nxt = 1'b0;
        if (!ctrl_r.silence) begin
            case (ctrl_r.src_sel)
                `AISP_SRC_LOOP: sdout_nxt = PA_SDATA_IN;
                `AISP_SRC_PORT_B: sdout_nxt = PB_SDATA_IN;
                default: sdout_nxt = 1'b0;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            ctrl_r <= CTRL_RST_WORD[6:0];
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
            rx_sum_r <= 1'b0;
            tx_sum_r <= 1'b0;
            sdout_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            rx_sum_r <= rx_sum_nxt;
            tx_sum_r <= tx_sum_nxt;
            sdout_r <= sdout_nxt;
        end
    end

    aisp_fmt_dec u_fmt_dec (
        .fmt(ctrl_r.fmt),
        .dec(fmt_dec)
    );

    // one decode feeds both directions so they can never disagree
    assign PA_IN_FMT = fmt_dec;
    assign PA_OUT_FMT = fmt_dec;
    assign PA_CTRL = ctrl_r;
    assign HOST_RDATA = rdata_r;
    assign HOST_RVALID = rvalid_r;
    assign PA_SDATA_OUT = sdout_r;

    // master drives the generated clocks out; slave listens on the pins
    assign PA_LEFT_RIGHT_FRAME_CLOCK_OE = ctrl_r.master;
    assign PA_BCK_OE = ctrl_r.master;
    assign PA_LEFT_RIGHT_FRAME_CLOCK_O = ctrl_r.master & PA_LEFT_RIGHT_FRAME_CLOCK_GEN;
    assign PA_BCK_O = ctrl_r.master & PA_BCK_GEN;
    assign PA_LEFT_RIGHT_FRAME_CLOCK_USE = ctrl_r.master ? PA_LEFT_RIGHT_FRAME_CLOCK_GEN : PA_LEFT_RIGHT_FRAME_CLOCK_I;
    assign PA_BCK_USE = ctrl_r.master ? PA_BCK_GEN : PA_BCK_I;

    AST_SUM_RX: assert property (
        @(posedge CORE_CLK) disable iff (!RESETN)
        HOST_RD && HOST_ADDR == `AISP_ADDR_IRQ_SUM
        |=> HOST_RVALID && HOST_RDATA[`AISP_SUM_RX_BIT] == $past(rx_sum_r))
        else $error("receiver flag read mismatch");
    AST_SUM_TX: assert property (
        @(posedge CORE_CLK) disable iff (!RESETN)
        HOST_RD && HOST_ADDR == `AISP_ADDR_IRQ_SUM
        |=> HOST_RDATA[`AISP_SUM_TX_BIT] == $past(tx_sum_r))
        else $error("transmitter flag read mismatch");
    AST_SUM_ZERO: assert property (
        @(posedge CORE_CLK) disable iff (!RESETN)
        HOST_RD && HOST_ADDR == `AISP_ADDR_IRQ_SUM
        |=> (HOST_RDATA & 8'hf9) == 8'h00)
        else $error("summary reserved bits nonzero");
    AST_RVALID: assert property (
        @(posedge CORE_CLK) disable iff (!RESETN)
        1'b1 |=> HOST_RVALID == $past(HOST_RD))
        else $error("read answer not one cycle after strobe");
    AST_RX_FLAG: assert property (
        @(posedge CORE_CLK) disable iff (!RESETN)
        ##1 rx_sum_r == $past(|(RX_PENDING & RX_ENABLE)))
        else $error("receiver summary not OR of sources");
    AST_RX_CLEAR: assert property (
        @(posedge CORE_CLK) disable iff (!RESETN)
        (RX_PENDING & RX_ENABLE) == '0 |=> !rx_sum_r)
        else $error("receiver flag stuck");
    AST_TX_FLAG: assert property (
        @(posedge CORE_CLK) disable iff (!RESETN)
        (TX_PENDING & TX_ENABLE) == '0 ##1 (TX_PENDING & TX_ENABLE) == '0
        |-> !tx_sum_r)
        else $error("transmitter flag stuck");
    AST_CTRL_RB: assert property (
        @(posedge CORE_CLK) disable iff (!RESETN)
        HOST_WR && HOST_ADDR == `AISP_ADDR_PA_CTRL1 ##1
        HOST_RD && !HOST_WR && HOST_ADDR == `AISP_ADDR_PA_CTRL1
        |=> HOST_RDATA == ($past(HOST_WDATA, 2) & 8'h7f))
        else $error("control readback wrong");
    AST_SILENCE: assert property (
        @(posedge CORE_CLK) disable iff (!RESETN)
        ctrl_r.silence |=> !PA_SDATA_OUT)
        else $error("muted port drives data");
    AST_FMT_BOTH: assert property (
        @(posedge CORE_CLK) disable iff (!RESETN)
        PA_IN_FMT == PA_OUT_FMT)
        else $error("format paths differ");
    AST_FMT_I2S: assert property (
        @(posedge CORE_CLK) disable iff (!RESETN)
        ctrl_r.fmt == `AISP_FMT_I2S24
        |-> PA_IN_FMT.just == aisp_pkg::AISP_JUST_I2S
        && PA_IN_FMT.word_len == `AISP_WLEN_24)
        else $error("i2s decode wrong");
    AST_FMT_RJ16: assert property (
        @(posedge CORE_CLK) disable iff (!RESETN)
        ctrl_r.fmt == `AISP_FMT_RJ16
        |-> PA_OUT_FMT.just == aisp_pkg::AISP_JUST_RIGHT
        && PA_OUT_FMT.word_len == `AISP_WLEN_16)
        else $error("right justified decode wrong");
    AST_FMT_UNUSED: assert property (
        @(posedge CORE_CLK) disable iff (!RESETN)
        ctrl_r.fmt == `AISP_FMT_UNUSED_A || ctrl_r.fmt == `AISP_FMT_UNUSED_B
        |-> !PA_IN_FMT.valid)
        else $error("unused format marked valid");
    AST_ROLE: assert property (
        @(posedge CORE_CLK) disable iff (!RESETN)
        !ctrl_r.master |-> !PA_LEFT_RIGHT_FRAME_CLOCK_OE && !PA_BCK_OE
        && PA_BCK_USE == PA_BCK_I)
        else $error("slave drives clocks");
    AST_MASTER: assert property (
        @(posedge CORE_CLK) disable iff (!RESETN)
        ctrl_r.master |-> PA_LEFT_RIGHT_FRAME_CLOCK_OE && PA_BCK_OE
        && PA_LEFT_RIGHT_FRAME_CLOCK_USE == PA_LEFT_RIGHT_FRAME_CLOCK_GEN && PA_BCK_USE == PA_BCK_GEN)
        else $error("master does not drive clocks");
    AST_LOOP: assert property (
        @(posedge CORE_CLK) disable iff (!RESETN)
        !ctrl_r.silence && ctrl_r.src_sel == `AISP_SRC_LOOP
        && !ctrl_nxt.silence && ctrl_nxt.src_sel == `AISP_SRC_LOOP
        |=> PA_SDATA_OUT == $past(PA_SDATA_IN))
        else $error("loopback data wrong");
    AST_PORTB: assert property (
        @(posedge CORE_CLK) disable iff (!RESETN)
        !ctrl_r.silence && ctrl_r.src_sel == `AISP_SRC_PORT_B
        |=> PA_SDATA_OUT == $past(PB_SDATA_IN))
        else $error("port B data wrong");
    COV_RX: cover property (@(posedge CORE_CLK) disable iff (!RESETN)
        !rx_sum_r ##1 rx_sum_r ##[1:8] !rx_sum_r);
    COV_TX: cover property (@(posedge CORE_CLK) disable iff (!RESETN)
        !tx_sum_r ##1 tx_sum_r);
    COV_MASTER: cover property (@(posedge CORE_CLK) disable iff (!RESETN)
        !ctrl_r.master ##1 ctrl_r.master);
    COV_PORTB: cover property (@(posedge CORE_CLK) disable iff (!RESETN)
        ctrl_r.src_sel == `AISP_SRC_PORT_B && !ctrl_r.silence);
    COV_RJ16: cover property (@(posedge CORE_CLK) disable iff (!RESETN)
        ctrl_r.fmt == `AISP_FMT_RJ16);
endmodule : aisp_bank

// *** tb/aisp_host.sv ***
// host controller model: byte reads and writes on the strobe port
// assumes the bank answers a read exactly one cycle after the strobe
`timescale 1ns/1ns
module aisp_host (
    input wire logic clk,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    output logic wr,
    output logic rd,
    output logic [7:0] addr,
    output logic [7:0] wdata
);
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        // released bus shows the inverse, never the stale value
        addr <= ~a;
        wdata <= ~d;
        #1;
    endtask : put
    task automatic get(input logic [7:0] a, output logic [7:0] d,
                       output logic v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        v = rvalid;
        d = rdata;
    endtask : get
    task automatic put_get(input logic [7:0] a, input logic [7:0] d,
                           output logic [7:0] q, output logic v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        // read in the very next cycle, same address kept
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        #1;
        v = rvalid;
        q = rdata;
    endtask : put_get
endmodule : aisp_host

// *** tb/audio_irq_status_port_a_ctrl_test.sv ***
// bench for the summary/port A bank, driven through the host model
// assumes default source counts and the one-cycle read answer
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    error_cnt++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module audio_irq_status_port_a_ctrl_test;
    logic clk = 1'b0, rst_n = 1'b0, wr, rd, vld, pa_sd = 1'b0;
    logic pb_sd = 1'b0, l_i = 1'b0, b_i = 1'b1, l_g = 1'b1, b_g = 1'b0;
    logic [7:0] addr, wdata, rdata;
    logic [15:0] rxp = 16'h0000, rxe = 16'h0000;
    logic [7:0] txp = 8'h00, txe = 8'h00;
    logic sd_o, l_o, l_oe, b_o, b_oe, l_u, b_u;
    aisp_pkg::aisp_pa_ctrl_t ctrl;
    aisp_pkg::aisp_fmt_t f_in, f_out;
    int error_cnt = 0, checks_done = 0;
    always #5 clk = ~clk;
    aisp_host i_host (.clk(clk), .rdata(rdata), .rvalid(vld), .wr(wr),
        .rd(rd), .addr(addr), .wdata(wdata));
    aisp_bank i_dut (.CORE_CLK(clk), .RESETN(rst_n), .HOST_WR(wr),
        .HOST_RD(rd), .HOST_ADDR(addr), .HOST_WDATA(wdata),
        .HOST_RDATA(rdata), .HOST_RVALID(vld), .RX_PENDING(rxp),
        .RX_ENABLE(rxe), .TX_PENDING(txp), .TX_ENABLE(txe), .PA_CTRL(ctrl),
        .PA_IN_FMT(f_in), .PA_OUT_FMT(f_out), .PA_SDATA_IN(pa_sd),
        .PB_SDATA_IN(pb_sd), .PA_SDATA_OUT(sd_o), .PA_LEFT_RIGHT_FRAME_CLOCK_I(l_i),
        .PA_BCK_I(b_i), .PA_LEFT_RIGHT_FRAME_CLOCK_GEN(l_g), .PA_BCK_GEN(b_g),
        .PA_LEFT_RIGHT_FRAME_CLOCK_O(l_o), .PA_LEFT_RIGHT_FRAME_CLOCK_OE(l_oe), .PA_BCK_O(b_o),
        .PA_BCK_OE(b_oe), .PA_LEFT_RIGHT_FRAME_CLOCK_USE(l_u), .PA_BCK_USE(b_u));
    task automatic report_and_stop();
        if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic v;
        i_host.get(a, d, v);
        `CHK("rvalid", 1'b1, v)
        `CHK("rdata", e, d)
    endtask : rdchk
    task automatic rbchk(input logic [7:0] a, input logic [7:0] w,
                         input logic [7:0] e);
        logic [7:0] d;
        logic v;
        i_host.put_get(a, w, d, v);
        `CHK("rb_valid", 1'b1, v)
        `CHK("rb_data", e, d)
    endtask : rbchk
    task automatic irq(input logic [15:0] p, input logic [15:0] en,
                       input logic [7:0] tp, input logic [7:0] te,
                       input logic [7:0] e);
        @(posedge clk);
        rxp <= p;
        rxe <= en;
        txp <= tp;
        txe <= te;
        repeat (2) @(posedge clk);
        rdchk(8'h02, e);
    endtask : irq
    task automatic sd(input logic [7:0] c, input logic a, input logic b,
                      input logic e);
        i_host.put(8'h03, c);
        @(posedge clk);
        pa_sd <= a;
        pb_sd <= b;
        repeat (2) @(posedge clk);
        #1;
        `CHK("sdout", e, sd_o)
    endtask : sd
    function automatic aisp_pkg::aisp_fmt_t exp_fmt(input logic [2:0] f);
        case (f)
            3'h0: exp_fmt = '{aisp_pkg::AISP_JUST_LEFT, 5'h18, 1'b1};
            3'h1: exp_fmt = '{aisp_pkg::AISP_JUST_I2S, 5'h18, 1'b1};
            3'h4: exp_fmt = '{aisp_pkg::AISP_JUST_RIGHT, 5'h10, 1'b1};
            3'h5: exp_fmt = '{aisp_pkg::AISP_JUST_RIGHT, 5'h12, 1'b1};
            3'h6: exp_fmt = '{aisp_pkg::AISP_JUST_RIGHT, 5'h14, 1'b1};
            3'h7: exp_fmt = '{aisp_pkg::AISP_JUST_RIGHT, 5'h18, 1'b1};
            default: exp_fmt = '{aisp_pkg::AISP_JUST_NONE, 5'h00, 1'b0};
        endcase
    endfunction : exp_fmt
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        logic [2:0] codes [8] = '{3'h0, 3'h1, 3'h4, 3'h2, 3'h3, 3'h5, 3'h6,
                                  3'h7};
        aisp_pkg::aisp_fmt_t ef;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(8'h02, 8'h00);
        rdchk(8'h03, 8'h00);
        `CHK("fmt_rst", exp_fmt(3'h0), f_in)
        irq(16'h0008, 16'h0008, 8'h00, 8'h00, 8'h02);
        rdchk(8'h14, 8'h00);
        rdchk(8'h15, 8'h00);
        irq(16'h0008, 16'h0000, 8'h00, 8'h00, 8'h00);
        irq(16'h0000, 16'h0000, 8'h80, 8'h80, 8'h04);
        rdchk(8'h0a, 8'h00);
        irq(16'h8000, 16'hffff, 8'h01, 8'h01, 8'h06);
        irq(16'h0000, 16'hffff, 8'h00, 8'hff, 8'h00);
        i_host.put(8'h02, 8'hff);
        rdchk(8'h02, 8'h00);
        i_host.put(8'h03, 8'hff);
        rdchk(8'h03, 8'h7f);
        rbchk(8'h03, 8'hc5, 8'h45);
        rbchk(8'h02, 8'hff, 8'h00);
        foreach (codes[i]) begin
            i_host.put(8'h03, {5'h00, codes[i]});
            ef = exp_fmt(codes[i]);
            `CHK("fmt_same", f_in, f_out)
            `CHK("fmt_valid", ef.valid, f_in.valid)
            if (ef.valid) `CHK("fmt", ef, f_in)
        end
        i_host.put(8'h03, 8'h08);
        `CHK("master", 6'h36, {l_o, l_oe, b_o, b_oe, l_u, b_u})
        i_host.put(8'h03, 8'h00);
        `CHK("slave", 6'h01, {l_o, l_oe, b_o, b_oe, l_u, b_u})
        sd(8'h00, 1'b1, 1'b0, 1'b1);
        sd(8'h10, 1'b1, 1'b0, 1'b0);
        sd(8'h10, 1'b0, 1'b1, 1'b1);
        sd(8'h50, 1'b1, 1'b1, 1'b0);
        sd(8'h20, 1'b1, 1'b1, 1'b0);
        i_host.put(8'h03, 8'h5d);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(8'h03, 8'h00);
        `CHK("fmt_rst2", exp_fmt(3'h0), f_in)
        `CHK("oe_rst", 2'h0, {l_oe, b_oe})
        report_and_stop();
    end
endmodule : audio_irq_status_port_a_ctrl_test
